// File: tb/serial_link_chk.sv
`default_nettype none
module serial_link_chk
  import serial_pkg::*;
#(
  parameter int BAUD_RATE = 5_000_000
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // serial lines
  input wire logic dev_to_node,
  input wire logic node_to_dev
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int CPB   = CLK_HZ / BAUD_RATE;
  localparam int FRAME = 11 * CPB;
  int f_cnt_q;
  int d_low_q;
  int n_low_q;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // clock index within a device frame, 0 when idle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) f_cnt_q <= 0;
    else if (f_cnt_q == 0) f_cnt_q <= dev_to_node ? 0 : 1;
    else f_cnt_q <= (f_cnt_q == FRAME - 1) ? 0 : f_cnt_q + 1;
  end
  // length of the current low run on each line
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      d_low_q <= 0;
      n_low_q <= 0;
    end else begin
      d_low_q <= dev_to_node ? 0 : d_low_q + 1;
      n_low_q <= node_to_dev ? 0 : n_low_q + 1;
    end
  end
  a_reset_idle_high: assert property ($rose(rst_n) |-> dev_to_node && node_to_dev)
    else $error("line not idle high after reset");
  a_start_bit_low: assert property (f_cnt_q inside {[1:CPB-1]} |-> !dev_to_node)
    else $error("start bit cut short");
  a_stop_bit_high: assert property (f_cnt_q >= 10 * CPB |-> dev_to_node)
    else $error("stop bit not high");
  a_bit_cells_stable: assert property (f_cnt_q != 0 && f_cnt_q % CPB != 0 |-> $stable(dev_to_node))
    else $error("device line moved inside a bit cell");
  a_dev_low_runs: assert property ($rose(dev_to_node) |-> d_low_q % CPB == 0)
    else $error("device low run not whole bits");
  a_node_low_runs: assert property ($rose(node_to_dev) |-> n_low_q % CPB == 0)
    else $error("node low run not whole bits");
  a_dev_run_bounded: assert property (d_low_q <= 10 * CPB)
    else $error("device line low too long");
  a_node_run_bounded: assert property (n_low_q <= 10 * CPB)
    else $error("node line low too long");
  // main scenarios
  cover property (f_cnt_q == FRAME - 1 ##2 !dev_to_node);
  cover property (f_cnt_q == 10 * CPB);
  cover property ($rose(node_to_dev));
endmodule : serial_link_chk
`default_nettype wire

// File: tb/test_nine_bit_async_serial_multiproc.sv
`default_nettype none
module test_nine_bit_async_serial_multiproc
  import serial_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int BAUD = 5_000_000;
  localparam int FRM  = 11 * (CLK_HZ / BAUD) + 20;
  logic              clk = 1'b0;
  logic              rst_n;
  logic [ADDR_W-1:0] addr;
  logic [7:0]        wdata;
  logic              wr;
  logic              rd;
  logic [7:0]        rdata;
  logic              irq_enable;
  logic              irq;
  logic              tx_ready;
  logic              nine_bit_mode;
  logic              send_valid;
  logic [8:0]        send_word;
  logic              send_ready;
  logic              rcv_valid;
  logic [8:0]        rcv_word;
  logic [7:0]        d;
  int                miscompares = 0;
  int                n_compared = 0;
  int                ticks = 0;
  int                i;
  serial_link_if serial_link_if_i ();
  serial_device #(.BAUD_RATE(BAUD)) serial_device_i (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .irq_enable(irq_enable), .irq(irq), .tx_ready(tx_ready),
    .link(serial_link_if_i.device));
  serial_node #(.BAUD_RATE(BAUD)) serial_node_i (.clk(clk), .rst_n(rst_n), .nine_bit_mode(nine_bit_mode),
    .send_valid(send_valid), .send_word(send_word), .send_ready(send_ready), .rcv_valid(rcv_valid),
    .rcv_word(rcv_word), .link(serial_link_if_i.node));
  serial_link_chk #(.BAUD_RATE(BAUD)) serial_link_chk_i (.clk(clk), .rst_n(rst_n),
    .dev_to_node(serial_link_if_i.dev_to_node), .node_to_dev(serial_link_if_i.node_to_dev));
  // clock and hang guard
  always #10 clk = ~clk;
  always @(posedge clk) begin
    ticks++;
    if (ticks == 60000) hang();
  end
  task test_done();
    $display("compared %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : test_done
  task hang();
    miscompares++;
    test_done();
  endtask : hang
  task chk(input logic [8:0] got, input logic [8:0] exp);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc
  // register port, one strobe per access
  // each access starts right after a rising edge, wherever the caller stood
  task reg_wr(input logic [ADDR_W-1:0] a, input logic [7:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : reg_wr
  // read data taken at the edge that closes the cycle after the strobe
  task reg_rd(input logic [ADDR_W-1:0] a, output logic [7:0] v);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(posedge clk);
    v = rdata;
  endtask : reg_rd
  // node send side, bounded wait for ready
  task node_send(input logic [8:0] w);
    @(negedge clk);
    for (i = 0; i < 300 && send_ready !== 1'b1; i++) @(negedge clk);
    if (i == 300) hang();
    @(posedge clk);
    send_valid <= 1'b1;
    send_word <= w;
    @(posedge clk);
    send_valid <= 1'b0;
    cyc(FRM);
  endtask : node_send
  task node_recv(input logic [8:0] w);
    @(negedge clk);
    for (i = 0; i < 400 && rcv_valid !== 1'b1; i++) @(negedge clk);
    if (i == 400) hang();
    chk(rcv_word, w);
  endtask : node_recv
  // main sequence
  initial begin
    {rst_n, addr, wdata, wr, rd, irq_enable, send_valid, send_word} = '0;
    nine_bit_mode = 1'b1;
    cyc(5);
    rst_n <= 1'b1;
    @(negedge clk);
    chk(serial_link_if_i.dev_to_node, 1'b1);
    reg_rd(REG_CONTROL, d); chk(d, CTRL_RESET);
    reg_rd(REG_DATA, d); chk(d, DATA_RESET);
    reg_rd(REG_STATUS, d); chk(d[0], 1'b1);
    reg_rd(2'h3, d); chk(d, 8'h00);
    irq_enable <= 1'b1;
    for (int k = 0; k < 2; k++) begin
      reg_wr(REG_CONTROL, k ? 8'h88 : 8'h80);
      reg_wr(REG_DATA, k ? 8'hA5 : 8'h5A);
      for (i = 0; i < 20 && serial_link_if_i.dev_to_node !== 1'b0; i++) @(negedge clk);
      if (i == 20) hang();
      // first read samples the last clock of the ninth bit, second the stop bit
      cyc(10 * (CLK_HZ / BAUD) - 2);
      reg_rd(REG_CONTROL, d); chk(d[BIT_TI], 1'b0);
      reg_rd(REG_CONTROL, d); chk(d[BIT_TI], 1'b1);
      node_recv({k[0], k ? 8'hA5 : 8'h5A});
      cyc(20);
      @(negedge clk); chk(irq, 1'b1);
      reg_wr(REG_CONTROL, 8'h80);
      cyc(2);
      @(negedge clk); chk(irq, 1'b0);
    end
    // receiver off, then on, then overrun
    node_send(9'h13C);
    reg_rd(REG_CONTROL, d); chk(d[BIT_RI], 1'b0);
    reg_wr(REG_CONTROL, 8'h90);
    node_send(9'h13C);
    reg_rd(REG_DATA, d); chk(d, 8'h3C);
    reg_rd(REG_CONTROL, d); chk(d, 8'h95);
    @(negedge clk); chk(irq, 1'b1);
    @(posedge clk);
    irq_enable <= 1'b0;
    cyc(2);
    @(negedge clk); chk(irq, 1'b0);
    @(posedge clk);
    irq_enable <= 1'b1;
    node_send(9'h077);
    reg_rd(REG_DATA, d); chk(d, 8'h3C);
    reg_rd(REG_CONTROL, d); chk(d, 8'h95);
    // filtering passes address bytes only
    reg_wr(REG_CONTROL, 8'hB0);
    node_send(9'h011);
    reg_rd(REG_CONTROL, d); chk(d, 8'hB0);
    node_send(9'h122);
    reg_rd(REG_CONTROL, d); chk(d, 8'hB5);
    reg_rd(REG_DATA, d); chk(d, 8'h22);
    // address matched: filter off, data byte taken, then filter on again
    reg_wr(REG_CONTROL, 8'h90);
    node_send(9'h033);
    reg_rd(REG_DATA, d); chk(d, 8'h33);
    reg_rd(REG_CONTROL, d); chk(d, 8'h91);
    reg_wr(REG_CONTROL, 8'hB0);
    node_send(9'h044);
    reg_rd(REG_DATA, d); chk(d, 8'h33);
    reg_rd(REG_CONTROL, d); chk(d, 8'hB0);
    // eight-bit frames, stop bit into ninth field
    nine_bit_mode <= 1'b0;
    reg_wr(REG_CONTROL, 8'h30);
    node_send(9'h081);
    reg_rd(REG_DATA, d); chk(d, 8'h81);
    reg_rd(REG_CONTROL, d); chk(d, 8'h35);
    nine_bit_mode <= 1'b1;
    // fill the transmit queue past its depth
    reg_wr(REG_CONTROL, 8'h80);
    for (int k = 0; k < FIFO_DEPTH + 2; k++) reg_wr(REG_DATA, 8'(8'hC0 + k));
    @(negedge clk); chk(tx_ready, 1'b0);
    reg_rd(REG_STATUS, d); chk(d[0], 1'b0);
    for (int k = 0; k < FIFO_DEPTH + 1; k++) node_recv({1'b0, 8'(8'hC0 + k)});
    cyc(20);
    reg_rd(REG_STATUS, d); chk(d[0], 1'b1);
    test_done();
  end
endmodule : test_nine_bit_async_serial_multiproc
`default_nettype wire

// File: verilog/serial_device.sv
`default_nettype none
module tx_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rst_n,
  // fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [PW-1:0] LAST = PW'(DEPTH - 1);
  localparam logic [CW-1:0] FULL = CW'(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [PW-1:0]    wr_ptr_q;
  logic [PW-1:0]    rd_ptr_q;
  logic [CW-1:0]    count_q;
  logic             push;
  logic             pop;

  // handshake terms
  assign in_ready  = (count_q != FULL);
  assign out_valid = (count_q != '0);
  assign out_data  = mem_q[rd_ptr_q];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  // storage write
  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wr_ptr_q] <= in_data;
    end
  end

  // pointers and fill level
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q  <= '0;
    end else begin
      if (push) begin
        wr_ptr_q <= (wr_ptr_q == LAST) ? '0 : wr_ptr_q + 1'b1;
      end
      if (pop) begin
        rd_ptr_q <= (rd_ptr_q == LAST) ? '0 : rd_ptr_q + 1'b1;
      end
      if (push && !pop) begin
        count_q <= count_q + 1'b1;
      end else if (pop && !push) begin
        count_q <= count_q - 1'b1;
      end
    end
  end
endmodule : tx_fifo

module serial_device #(
  parameter int BAUD_RATE = serial_pkg::BAUD_DEFAULT
) (
  // clock and reset
  input  wire logic                          clk,
  input  wire logic                          rst_n,
  // register port
  input  wire logic [serial_pkg::ADDR_W-1:0] addr,
  input  wire logic [7:0]                    wdata,
  input  wire logic                          wr,
  input  wire logic                          rd,
  output logic [7:0]                         rdata,
  // interrupt and flow
  input  wire logic                          irq_enable,
  output logic                               irq,
  output logic                               tx_ready,
  // serial link
  serial_link_if.device                      link
);
  import serial_pkg::*;

  localparam int CLKS_PER_BIT = CLK_HZ / BAUD_RATE;
  localparam logic [TIMER_W-1:0] FULL_BIT = TIMER_W'(CLKS_PER_BIT - 1);
  localparam logic [TIMER_W-1:0] HALF_BIT = TIMER_W'(CLKS_PER_BIT / 2 - 1);

  // control fields
  logic       mode_q, mce_q, ren_q, tb8_q, rb8_q, ti_q, ri_q;
  logic [7:0] rx_buf_q;
  logic [7:0] rdata_q;
  logic       irq_q, tx_ready_q, txd_q;
  // receive pin filter
  logic       rx_s1_q, rx_s2_q, rx_s3_q, rx_filt_q, rx_prev_q;
  // engines
  phase_e             tx_ph_q, rx_ph_q;
  logic [TIMER_W-1:0] tx_tmr_q, rx_tmr_q;
  logic [3:0]         tx_idx_q, rx_idx_q;
  logic [8:0]         tx_sh_q, rx_sh_q;
  logic               rx_load, tx_stop_start, ctrl_wr;
  logic               fifo_ready, fifo_valid, fifo_pop;
  logic [7:0]         fifo_data;
  logic               rx_ninth;

  // number of data bits in a frame, ninth included in 9-bit mode
  function automatic logic [3:0] frame_bits(input logic mode);
    frame_bits = mode ? 4'h9 : 4'h8;
  endfunction : frame_bits

  assign ctrl_wr = wr && (addr == REG_CONTROL);

  // transmit queue behind the data buffer
  tx_fifo #(.WIDTH(DATA_BITS), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk       (clk),
    .rst_n     (rst_n),
    .in_valid  (wr && (addr == REG_DATA)),
    .in_ready  (fifo_ready),
    .in_data   (wdata),
    .out_valid (fifo_valid),
    .out_ready (fifo_pop),
    .out_data  (fifo_data)
  );
  assign fifo_pop = (tx_ph_q == PH_IDLE);

  // software-owned control bits
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_q <= CTRL_RESET[BIT_MODE];
      mce_q  <= CTRL_RESET[BIT_MCE];
      ren_q  <= CTRL_RESET[BIT_REN];
      tb8_q  <= CTRL_RESET[BIT_TB8];
    end else if (ctrl_wr) begin
      mode_q <= wdata[BIT_MODE];
      mce_q  <= wdata[BIT_MCE];
      ren_q  <= wdata[BIT_REN];
      tb8_q  <= wdata[BIT_TB8];
    end
  end

  // flags: hardware set wins over a software write
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ti_q  <= CTRL_RESET[BIT_TI];
      ri_q  <= CTRL_RESET[BIT_RI];
      rb8_q <= CTRL_RESET[BIT_RB8];
    end else begin
      if (tx_stop_start) begin
        ti_q <= 1'b1;
      end else if (ctrl_wr) begin
        ti_q <= wdata[BIT_TI];
      end
      if (rx_load) begin
        ri_q  <= 1'b1;
        rb8_q <= rx_ninth;
      end else if (ctrl_wr) begin
        ri_q  <= wdata[BIT_RI];
        rb8_q <= wdata[BIT_RB8];
      end
    end
  end

  // read port, data one cycle after the strobe
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= 8'h00;
    end else if (rd) begin
      unique case (addr)
        REG_CONTROL: rdata_q <= {mode_q, 1'b0, mce_q, ren_q, tb8_q, rb8_q, ti_q, ri_q};
        REG_DATA:    rdata_q <= rx_buf_q;
        REG_STATUS:  rdata_q <= {7'h00, fifo_ready};
        default:     rdata_q <= 8'h00;
      endcase
    end
  end

  // interrupt request and queue space
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_q      <= 1'b0;
      tx_ready_q <= 1'b0;
    end else begin
      irq_q      <= irq_enable && (ti_q || ri_q);
      tx_ready_q <= fifo_ready;
    end
  end

  // transmit engine
  assign tx_stop_start = (tx_ph_q == PH_DATA) && (tx_tmr_q == '0)
                         && (tx_idx_q == frame_bits(mode_q) - 4'h1);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_ph_q  <= PH_IDLE;
      tx_tmr_q <= '0;
      tx_idx_q <= 4'h0;
      tx_sh_q  <= 9'h000;
      txd_q    <= 1'b1;
    end else begin
      tx_tmr_q <= (tx_tmr_q == '0) ? FULL_BIT : tx_tmr_q - 1'b1;
      unique case (tx_ph_q)
        PH_IDLE: begin
          txd_q <= 1'b1;
          if (fifo_valid) begin
            tx_sh_q  <= {tb8_q, fifo_data};
            tx_ph_q  <= PH_START;
            tx_tmr_q <= FULL_BIT;
            txd_q    <= 1'b0;
          end
        end
        PH_START: begin
          if (tx_tmr_q == '0) begin
            tx_ph_q  <= PH_DATA;
            tx_idx_q <= 4'h0;
            txd_q    <= tx_sh_q[0];
          end
        end
        PH_DATA: begin
          if (tx_tmr_q == '0) begin
            if (tx_stop_start) begin
              tx_ph_q <= PH_STOP;
              txd_q   <= 1'b1;
            end else begin
              tx_idx_q <= tx_idx_q + 4'h1;
              txd_q    <= tx_sh_q[tx_idx_q + 4'h1];
            end
          end
        end
        PH_STOP: begin
          if (tx_tmr_q == '0) begin
            tx_ph_q <= PH_IDLE;
          end
        end
      endcase
    end
  end

  // receive pin: three stages, change taken when stages two and three agree
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_s1_q   <= 1'b1;
      rx_s2_q   <= 1'b1;
      rx_s3_q   <= 1'b1;
      rx_filt_q <= 1'b1;
      rx_prev_q <= 1'b1;
    end else begin
      rx_s1_q   <= link.node_to_dev;
      rx_s2_q   <= rx_s1_q;
      rx_s3_q   <= rx_s2_q;
      rx_filt_q <= (rx_s2_q == rx_s3_q) ? rx_s3_q : rx_filt_q;
      rx_prev_q <= rx_filt_q;
    end
  end

  // load decision at the stop-bit sample
  assign rx_ninth = mode_q ? rx_sh_q[8] : rx_filt_q;
  assign rx_load  = (rx_ph_q == PH_STOP) && (rx_tmr_q == '0) && ren_q
                    && !ri_q && (!mce_q || rx_ninth);

  // receive engine
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_ph_q  <= PH_IDLE;
      rx_tmr_q <= '0;
      rx_idx_q <= 4'h0;
      rx_sh_q  <= 9'h000;
    end else if (!ren_q) begin
      rx_ph_q <= PH_IDLE;
    end else begin
      rx_tmr_q <= (rx_tmr_q == '0) ? FULL_BIT : rx_tmr_q - 1'b1;
      unique case (rx_ph_q)
        PH_IDLE: begin
          if (rx_prev_q && !rx_filt_q) begin
            rx_ph_q  <= PH_START;
            rx_tmr_q <= HALF_BIT;
          end
        end
        PH_START: begin
          if (rx_tmr_q == '0) begin
            rx_ph_q  <= rx_filt_q ? PH_IDLE : PH_DATA;
            rx_idx_q <= 4'h0;
          end
        end
        PH_DATA: begin
          if (rx_tmr_q == '0) begin
            rx_sh_q[rx_idx_q] <= rx_filt_q;
            rx_idx_q <= rx_idx_q + 4'h1;
            if (rx_idx_q == frame_bits(mode_q) - 4'h1) begin
              rx_ph_q <= PH_STOP;
            end
          end
        end
        PH_STOP: begin
          if (rx_tmr_q == '0) begin
            rx_ph_q <= PH_IDLE;
          end
        end
      endcase
    end
  end

  // receive buffer
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_buf_q <= DATA_RESET;
    end else if (rx_load) begin
      rx_buf_q <= rx_sh_q[7:0];
    end
  end

  assign rdata            = rdata_q;
  assign irq              = irq_q;
  assign tx_ready         = tx_ready_q;
  assign link.dev_to_node = txd_q;
endmodule : serial_device
`default_nettype wire

// File: verilog/serial_link_if.sv
`default_nettype none
interface serial_link_if;
  // serial lines, idle high
  logic dev_to_node;
  logic node_to_dev;
  modport device (output dev_to_node, input node_to_dev);
  modport node   (input dev_to_node, output node_to_dev);
endinterface : serial_link_if
`default_nettype wire

// File: verilog/serial_node.sv
`default_nettype none
module serial_node #(
  parameter int BAUD_RATE = serial_pkg::BAUD_DEFAULT
) (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // frame shape
  input  wire logic       nine_bit_mode,
  // send side
  input  wire logic       send_valid,
  input  wire logic [8:0] send_word,
  output logic            send_ready,
  // receive side
  output logic            rcv_valid,
  output logic [8:0]      rcv_word,
  // serial link
  serial_link_if.node     link
);
  import serial_pkg::*;

  localparam int CLKS_PER_BIT = CLK_HZ / BAUD_RATE;
  localparam logic [TIMER_W-1:0] FULL_BIT = TIMER_W'(CLKS_PER_BIT - 1);
  localparam logic [TIMER_W-1:0] HALF_BIT = TIMER_W'(CLKS_PER_BIT / 2 - 1);

  phase_e             tx_ph_q, rx_ph_q;
  logic [TIMER_W-1:0] tx_tmr_q, rx_tmr_q;
  logic [3:0]         tx_idx_q, rx_idx_q, nbits;
  logic [8:0]         tx_sh_q, rx_sh_q, rcv_word_q;
  logic               txd_q, ready_q, rcv_valid_q;
  logic               s1_q, s2_q, s3_q, filt_q, prev_q;

  // data bits per frame; word bit 8 is the address mark in 9-bit mode
  assign nbits = nine_bit_mode ? 4'h9 : 4'h8;

  // transmit engine
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_ph_q  <= PH_IDLE;
      tx_tmr_q <= '0;
      tx_idx_q <= 4'h0;
      tx_sh_q  <= 9'h000;
      txd_q    <= 1'b1;
      ready_q  <= 1'b0;
    end else begin
      tx_tmr_q <= (tx_tmr_q == '0) ? FULL_BIT : tx_tmr_q - 1'b1;
      ready_q  <= (tx_ph_q == PH_IDLE) && !(ready_q && send_valid);
      unique case (tx_ph_q)
        PH_IDLE: begin
          txd_q <= 1'b1;
          if (ready_q && send_valid) begin
            tx_sh_q  <= send_word;
            tx_ph_q  <= PH_START;
            tx_tmr_q <= FULL_BIT;
            txd_q    <= 1'b0;
          end
        end
        PH_START: begin
          if (tx_tmr_q == '0) begin
            tx_ph_q  <= PH_DATA;
            tx_idx_q <= 4'h0;
            txd_q    <= tx_sh_q[0];
          end
        end
        PH_DATA: begin
          if (tx_tmr_q == '0) begin
            if (tx_idx_q == nbits - 4'h1) begin
              tx_ph_q <= PH_STOP;
              txd_q   <= 1'b1;
            end else begin
              tx_idx_q <= tx_idx_q + 4'h1;
              txd_q    <= tx_sh_q[tx_idx_q + 4'h1];
            end
          end
        end
        PH_STOP: begin
          if (tx_tmr_q == '0) begin
            tx_ph_q <= PH_IDLE;
          end
        end
      endcase
    end
  end

  // receive pin filter
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_q   <= 1'b1;
      s2_q   <= 1'b1;
      s3_q   <= 1'b1;
      filt_q <= 1'b1;
      prev_q <= 1'b1;
    end else begin
      s1_q   <= link.dev_to_node;
      s2_q   <= s1_q;
      s3_q   <= s2_q;
      filt_q <= (s2_q == s3_q) ? s3_q : filt_q;
      prev_q <= filt_q;
    end
  end

  // receive engine, every frame reported
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_ph_q     <= PH_IDLE;
      rx_tmr_q    <= '0;
      rx_idx_q    <= 4'h0;
      rx_sh_q     <= 9'h000;
      rcv_word_q  <= 9'h000;
      rcv_valid_q <= 1'b0;
    end else begin
      rx_tmr_q    <= (rx_tmr_q == '0) ? FULL_BIT : rx_tmr_q - 1'b1;
      rcv_valid_q <= 1'b0;
      unique case (rx_ph_q)
        PH_IDLE: begin
          if (prev_q && !filt_q) begin
            rx_ph_q  <= PH_START;
            rx_tmr_q <= HALF_BIT;
            rx_sh_q  <= 9'h000;
          end
        end
        PH_START: begin
          if (rx_tmr_q == '0) begin
            rx_ph_q  <= filt_q ? PH_IDLE : PH_DATA;
            rx_idx_q <= 4'h0;
          end
        end
        PH_DATA: begin
          if (rx_tmr_q == '0) begin
            rx_sh_q[rx_idx_q] <= filt_q;
            rx_idx_q <= rx_idx_q + 4'h1;
            if (rx_idx_q == nbits - 4'h1) begin
              rx_ph_q <= PH_STOP;
            end
          end
        end
        PH_STOP: begin
          if (rx_tmr_q == '0) begin
            rx_ph_q     <= PH_IDLE;
            rcv_valid_q <= 1'b1;
            rcv_word_q  <= rx_sh_q;
          end
        end
      endcase
    end
  end

  assign send_ready       = ready_q;
  assign rcv_valid        = rcv_valid_q;
  assign rcv_word         = rcv_word_q;
  assign link.node_to_dev = txd_q;
endmodule : serial_node
`default_nettype wire

// File: verilog/serial_pkg.sv
`default_nettype none
package serial_pkg;
  // clocking and bit timing
  localparam int CLK_HZ       = 50_000_000;
  localparam int BAUD_DEFAULT = 115_200;
  localparam int TIMER_W      = 16;
  // register port
  localparam int ADDR_W = 2;
  localparam logic [ADDR_W-1:0] REG_CONTROL = 2'h0;
  localparam logic [ADDR_W-1:0] REG_DATA    = 2'h1;
  localparam logic [ADDR_W-1:0] REG_STATUS  = 2'h2;
  // control register fields
  localparam int BIT_MODE  = 7;
  localparam int BIT_MCE   = 5;
  localparam int BIT_REN   = 4;
  localparam int BIT_TB8   = 3;
  localparam int BIT_RB8   = 2;
  localparam int BIT_TI    = 1;
  localparam int BIT_RI    = 0;
  localparam int BIT_SPACE = 0;
  localparam logic [7:0] CTRL_RESET  = 8'h00;
  localparam logic [7:0] DATA_RESET  = 8'h00;
  // frame shape
  localparam int DATA_BITS  = 8;
  localparam int FIFO_DEPTH = 8;
  typedef enum logic [1:0] {
    PH_IDLE  = 2'b00,
    PH_START = 2'b01,
    PH_DATA  = 2'b10,
    PH_STOP  = 2'b11
  } phase_e;
endpackage : serial_pkg
`default_nettype wire
